/* verilog/sled_encoder.sv */
// status led encoder for the scanner front panel
`timescale 1ns/100ps
module sled_encoder #(
	parameter int BLINK_HALF_CYC = sled_pkg::SLED_BLINK_HALF_CYC
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic powered,
	input wire logic safety_output_pair_on,
	input wire logic error_present,
	input wire logic restart_interlock_enabled,
	input wire logic restart_interlock_released,
	input wire logic protective_field_occupied,
	input wire logic linked_sensor_enabled,
	input wire logic warning_field_interrupted,
	input wire logic four_field_mode,
	input wire logic warning_field3_interrupted,
	input wire logic warning_field2_interrupted,
	input wire logic self_test_fail,
	input wire logic internal_comm_fault,
	input wire logic locate_active,
	input wire logic proto_initialised,
	input wire logic proto_passive,
	input wire logic proto_active,
	input wire logic proto_config_fail,
	input wire logic proto_comm_error,
	input wire logic bus_initialised,
	input wire logic bus_initialising,
	input wire logic bus_data_exchange,
	input wire logic topology_error,
	input wire logic eth_config_fail,
	input wire logic bus_error,
	input wire logic port1_link,
	input wire logic port1_traffic,
	input wire logic port2_link,
	input wire logic port2_traffic,
	output sled_pkg::sled_colour_t led1,
	output sled_pkg::sled_colour_t led2,
	output sled_pkg::sled_colour_t led3,
	output sled_pkg::sled_colour_t led4,
	output sled_pkg::sled_colour_t led5,
	output sled_pkg::sled_colour_t led6,
	output sled_pkg::sled_colour_t power_indicator,
	output sled_pkg::sled_colour_t safety_proto_indicator,
	output sled_pkg::sled_colour_t network_indicator,
	output sled_pkg::sled_colour_t port1_link_indicator,
	output sled_pkg::sled_colour_t port2_link_indicator
);

	// refuse a blink half period the counter cannot serve
	if (BLINK_HALF_CYC < 1)
	begin
		$error("blink half period must be at least one cycle");
	end

	localparam int CW = (BLINK_HALF_CYC > 1) ? $clog2(BLINK_HALF_CYC) : 1;

	logic rst_meta;
	logic rst_sync;
	logic [CW-1:0] blink_cnt;
	logic blink;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// shared blink timebase
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end
		else if (blink_cnt == CW'(BLINK_HALF_CYC - 1))
		begin
			blink_cnt <= '0;
			blink <= ~blink;
		end
		else
			blink_cnt <= blink_cnt + CW'(1);
	end

	// flashing: colour in the on phase, off in the other
	function automatic sled_pkg::sled_colour_t flash(input sled_pkg::sled_colour_t c, input logic ph);
		flash = ph ? c : sled_pkg::SLED_OFF;
	endfunction

	// port link colour: dark without link, green idle, green and orange alternating with traffic
	function automatic sled_pkg::sled_colour_t link_colour(input logic link, input logic traffic, input logic ph);
		if (!link)
			link_colour = sled_pkg::SLED_OFF;
		else if (traffic)
			link_colour = ph ? sled_pkg::SLED_GREEN : sled_pkg::SLED_ORANGE;
		else
			link_colour = sled_pkg::SLED_GREEN;
	endfunction

	// led1: safety output pair state, flashing red on error; inputs are same-clock logic
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led1 <= sled_pkg::SLED_OFF;
		end
		else if (!powered)
		begin
			led1 <= sled_pkg::SLED_OFF;
		end
		else if (error_present)
		begin
			led1 <= flash(sled_pkg::SLED_RED, blink);
		end
		else if (safety_output_pair_on)
		begin
			led1 <= sled_pkg::SLED_GREEN;
		end
		else
		begin
			led1 <= sled_pkg::SLED_RED;
		end
	end

	// led2: restart interlock and protective field
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led2 <= sled_pkg::SLED_OFF;
		end
		else if (!powered)
		begin
			led2 <= sled_pkg::SLED_OFF;
		end
		else if (protective_field_occupied)
		begin
			led2 <= flash(sled_pkg::SLED_YELLOW, blink);
		end
		else if (restart_interlock_enabled && !restart_interlock_released && linked_sensor_enabled)
		begin
			led2 <= sled_pkg::SLED_YELLOW;
		end
		else
		begin
			led2 <= sled_pkg::SLED_OFF;
		end
	end

	// led3: warning field
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led3 <= sled_pkg::SLED_OFF;
		end
		else if (powered && warning_field_interrupted)
		begin
			led3 <= sled_pkg::SLED_BLUE;
		end
		else
		begin
			led3 <= sled_pkg::SLED_OFF;
		end
	end

	// led4: third warning field, four-field mode only
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led4 <= sled_pkg::SLED_OFF;
		end
		else if (powered && four_field_mode && warning_field3_interrupted)
		begin
			led4 <= sled_pkg::SLED_BLUE;
		end
		else
		begin
			led4 <= sled_pkg::SLED_OFF;
		end
	end

	// led5: second warning field, four-field mode only
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led5 <= sled_pkg::SLED_OFF;
		end
		else if (powered && four_field_mode && warning_field2_interrupted)
		begin
			led5 <= flash(sled_pkg::SLED_YELLOW, blink);
		end
		else
		begin
			led5 <= sled_pkg::SLED_OFF;
		end
	end

	// led6 has no function and stays dark
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			led6 <= sled_pkg::SLED_OFF;
		end
		else
		begin
			led6 <= sled_pkg::SLED_OFF;
		end
	end

	// power indicator: faults beat locate, locate beats healthy
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			power_indicator <= sled_pkg::SLED_OFF;
		end
		else if (!powered)
		begin
			power_indicator <= sled_pkg::SLED_OFF;
		end
		else if (self_test_fail || internal_comm_fault)
		begin
			power_indicator <= sled_pkg::SLED_RED;
		end
		else if (locate_active)
		begin
			power_indicator <= flash(sled_pkg::SLED_GREEN, blink);
		end
		else
		begin
			power_indicator <= sled_pkg::SLED_GREEN;
		end
	end

	// safety protocol indicator: errors, then locate or passive, then layer state
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			safety_proto_indicator <= sled_pkg::SLED_OFF;
		end
		else if (!powered)
		begin
			safety_proto_indicator <= sled_pkg::SLED_OFF;
		end
		else if (proto_comm_error)
		begin
			safety_proto_indicator <= sled_pkg::SLED_RED;
		end
		else if (proto_config_fail)
		begin
			safety_proto_indicator <= flash(sled_pkg::SLED_RED, blink);
		end
		else if (locate_active || proto_passive)
		begin
			safety_proto_indicator <= flash(sled_pkg::SLED_GREEN, blink);
		end
		else if (!proto_initialised)
		begin
			safety_proto_indicator <= sled_pkg::SLED_OFF;
		end
		else if (proto_active)
		begin
			safety_proto_indicator <= sled_pkg::SLED_GREEN;
		end
		else
		begin
			safety_proto_indicator <= sled_pkg::SLED_OFF;
		end
	end

	// network indicator: bus and ethernet errors, then locate or init, then exchange state
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			network_indicator <= sled_pkg::SLED_OFF;
		end
		else if (!powered)
		begin
			network_indicator <= sled_pkg::SLED_OFF;
		end
		else if (bus_error)
		begin
			network_indicator <= sled_pkg::SLED_RED;
		end
		else if (eth_config_fail)
		begin
			network_indicator <= flash(sled_pkg::SLED_RED, blink);
		end
		else if (topology_error)
		begin
			network_indicator <= flash(sled_pkg::SLED_ORANGE, blink);
		end
		else if (locate_active || bus_initialising)
		begin
			network_indicator <= flash(sled_pkg::SLED_GREEN, blink);
		end
		else if (bus_initialised && bus_data_exchange)
		begin
			network_indicator <= sled_pkg::SLED_GREEN;
		end
		else if (bus_initialised)
		begin
			network_indicator <= flash(sled_pkg::SLED_RED, blink); // no data exchange
		end
		else
		begin
			network_indicator <= sled_pkg::SLED_OFF;
		end
	end

	// port 1 link indicator
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			port1_link_indicator <= sled_pkg::SLED_OFF;
		end
		else
		begin
			port1_link_indicator <= powered ? link_colour(port1_link, port1_traffic, blink) : sled_pkg::SLED_OFF;
		end
	end

	// port 2 link indicator
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			port2_link_indicator <= sled_pkg::SLED_OFF;
		end
		else
		begin
			port2_link_indicator <= powered ? link_colour(port2_link, port2_traffic, blink) : sled_pkg::SLED_OFF;
		end
	end
endmodule

/* verilog/sled_pkg.sv */
// constants and types for the scanner status led encoder
// Summary of operation
// - led1: off unpowered, red safety pair off, green on, flashing red on error
// - led2 off when restart interlock disabled, or enabled and released
// - led2 flashes yellow while protective field occupied
// - led2 steady yellow when interlock blocking, field free, linked sensor enabled
// - led3 steady blue while warning field interrupted, else off
// - in four-field mode led4 steady blue while warning field 3 interrupted
// - in four-field mode led5 flashes yellow while warning field 2 interrupted
// - power indicator steady red on self-test or internal comms fault, off unpowered
// - power indicator steady green when healthy, flashing green during locate
// - safety protocol indicator off while layer uninitialised or off
// - safety protocol indicator flashes green when passive or locating
// - safety protocol indicator steady green when layer active
// - safety protocol indicator flashes red on configuration failure
// - safety protocol indicator steady red on communication error
// - network indicator off while fieldbus uninitialised or inactive
// - network indicator flashes green during initialisation or locate
// - network indicator steady green during cyclic data exchange
// - network indicator flashes orange on topology error
// - network indicator flashes red on config fail, no or invalid data
// - network indicator steady red on bus error without communication
// - port link indicators off without link, steady green when idle link
// - port link indicators alternate green and orange while traffic flows
package sled_pkg;
	// led colour encoding driven to the led drivers
	typedef enum logic [2:0]
	{
		SLED_OFF = 3'b000,
		SLED_RED = 3'b001,
		SLED_GREEN = 3'b010,
		SLED_YELLOW = 3'b011,
		SLED_BLUE = 3'b100,
		SLED_ORANGE = 3'b101
	} sled_colour_t;
	localparam int SLED_CLK_HZ = 125000000;
	// half period of the blink in ms, 2 Hz flash
	localparam int SLED_BLINK_HALF_MS = 250;
	localparam int SLED_BLINK_HALF_CYC = SLED_CLK_HZ / 1000 * SLED_BLINK_HALF_MS;
endpackage

/* tb/sled_assertions.sv */
// checker tying the led outputs except led2 and port2_link_indicator to the status inputs that cause them
`timescale 1ns/100ps
module sled_assertions (
	input logic clk,
	input logic rst_b,
	input logic powered,
	input logic error_present,
	input logic safety_output_pair_on,
	input logic self_test_fail,
	input logic internal_comm_fault,
	input logic proto_comm_error,
	input logic bus_error,
	input logic warning_field_interrupted,
	input logic four_field_mode,
	input logic warning_field2_interrupted,
	input logic port1_link,
	input logic port1_traffic,
	input sled_pkg::sled_colour_t led1,
	input sled_pkg::sled_colour_t led3,
	input sled_pkg::sled_colour_t led4,
	input sled_pkg::sled_colour_t led5,
	input sled_pkg::sled_colour_t led6,
	input sled_pkg::sled_colour_t power_indicator,
	input sled_pkg::sled_colour_t safety_proto_indicator,
	input sled_pkg::sled_colour_t network_indicator,
	input sled_pkg::sled_colour_t port1_link_indicator
);
	logic [1:0] up;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// edges since reset release, outputs valid once up[1] is seen
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end
	led6_dark_a: assert property (led6 == sled_pkg::SLED_OFF) else $error("led6 lit");
	unpowered_dark_a: assert property (up[1] && !powered |=> led1 == sled_pkg::SLED_OFF
		&& power_indicator == sled_pkg::SLED_OFF) else $error("lit while unpowered");
	pair_green_a: assert property (up[1] && powered && !error_present && safety_output_pair_on
		|=> led1 == sled_pkg::SLED_GREEN) else $error("led1 not green");
	error_flash_a: assert property (up[1] && powered && error_present |=> led1 inside
		{sled_pkg::SLED_RED, sled_pkg::SLED_OFF}) else $error("led1 not flashing red");
	four_field_gate_a: assert property (up[1] && !four_field_mode
		|=> led4 == sled_pkg::SLED_OFF && led5 == sled_pkg::SLED_OFF) else $error("led4 or led5 lit");
	in_phase_a: assert property (up[1] && powered && error_present && four_field_mode
		&& warning_field2_interrupted |=> (led1 == sled_pkg::SLED_RED) == (led5 == sled_pkg::SLED_YELLOW))
		else $error("flashers out of phase");
	power_fault_a: assert property (up[1] && powered && (self_test_fail || internal_comm_fault)
		|=> power_indicator == sled_pkg::SLED_RED) else $error("power not red");
	proto_comm_a: assert property (up[1] && powered && proto_comm_error
		|=> safety_proto_indicator == sled_pkg::SLED_RED) else $error("proto not red");
	bus_fault_a: assert property (up[1] && powered && bus_error
		|=> network_indicator == sled_pkg::SLED_RED) else $error("net not red");
	warn_blue_a: assert property (up[1] && powered && warning_field_interrupted
		|=> led3 == sled_pkg::SLED_BLUE) else $error("led3 not blue");
	idle_link_a: assert property (up[1] && powered && port1_link && !port1_traffic
		|=> port1_link_indicator == sled_pkg::SLED_GREEN) else $error("port1 not green");
endmodule
bind sled_encoder sled_assertions u_sled_assertions (.clk(clk), .rst_b(rst_b), .powered(powered),
	.error_present(error_present), .safety_output_pair_on(safety_output_pair_on),
	.self_test_fail(self_test_fail), .internal_comm_fault(internal_comm_fault),
	.proto_comm_error(proto_comm_error), .bus_error(bus_error),
	.warning_field_interrupted(warning_field_interrupted), .four_field_mode(four_field_mode),
	.warning_field2_interrupted(warning_field2_interrupted), .port1_link(port1_link),
	.port1_traffic(port1_traffic), .led1(led1), .led3(led3), .led4(led4), .led5(led5), .led6(led6),
	.power_indicator(power_indicator), .safety_proto_indicator(safety_proto_indicator),
	.network_indicator(network_indicator), .port1_link_indicator(port1_link_indicator));

/* tb/sled_panel.sv */
// operator model timing how long one led holds each colour
`timescale 1ns/100ps
module sled_panel (
	input logic clk,
	input sled_pkg::sled_colour_t led,
	output int run
);
	sled_pkg::sled_colour_t last;
	int cnt;
	// length of the last completed run between two colour changes
	always @(negedge clk)
	begin
		if (led !== last)
		begin
			run = cnt;
			cnt = 1;
		end
		else
			cnt++;
		last = led;
	end
endmodule

/* tb/testbench.sv */
// self-checking bench for the status led encoder
`timescale 1ns/100ps
module testbench;
	localparam int BHC = 4;
	logic clk, rst_b;
	logic powered, safety_output_pair_on, error_present, restart_interlock_enabled, restart_interlock_released,
		protective_field_occupied, linked_sensor_enabled, warning_field_interrupted, four_field_mode,
		warning_field3_interrupted, warning_field2_interrupted, self_test_fail, internal_comm_fault, locate_active,
		proto_initialised, proto_passive, proto_active, proto_config_fail, proto_comm_error, bus_initialised,
		bus_initialising, bus_data_exchange, topology_error, eth_config_fail, bus_error,
		port1_link, port1_traffic, port2_link, port2_traffic;
	sled_pkg::sled_colour_t led1, led2, led3, led4, led5, led6, power_indicator, safety_proto_indicator,
		network_indicator, port1_link_indicator, port2_link_indicator;
	sled_pkg::sled_colour_t o [11];
	int fails, samples_checked, run;
	sled_encoder #(.BLINK_HALF_CYC(BHC)) u_sled_encoder (.clk(clk), .rst_b(rst_b), .powered(powered),
		.safety_output_pair_on(safety_output_pair_on), .error_present(error_present),
		.restart_interlock_enabled(restart_interlock_enabled),
		.restart_interlock_released(restart_interlock_released),
		.protective_field_occupied(protective_field_occupied), .linked_sensor_enabled(linked_sensor_enabled),
		.warning_field_interrupted(warning_field_interrupted), .four_field_mode(four_field_mode),
		.warning_field3_interrupted(warning_field3_interrupted),
		.warning_field2_interrupted(warning_field2_interrupted), .self_test_fail(self_test_fail),
		.internal_comm_fault(internal_comm_fault), .locate_active(locate_active),
		.proto_initialised(proto_initialised), .proto_passive(proto_passive), .proto_active(proto_active),
		.proto_config_fail(proto_config_fail), .proto_comm_error(proto_comm_error),
		.bus_initialised(bus_initialised), .bus_initialising(bus_initialising),
		.bus_data_exchange(bus_data_exchange), .topology_error(topology_error),
		.eth_config_fail(eth_config_fail), .bus_error(bus_error), .port1_link(port1_link),
		.port1_traffic(port1_traffic), .port2_link(port2_link), .port2_traffic(port2_traffic),
		.led1(led1), .led2(led2), .led3(led3), .led4(led4), .led5(led5), .led6(led6),
		.power_indicator(power_indicator), .safety_proto_indicator(safety_proto_indicator),
		.network_indicator(network_indicator), .port1_link_indicator(port1_link_indicator),
		.port2_link_indicator(port2_link_indicator));
	sled_panel u_sled_panel (.clk(clk), .led(port1_link_indicator), .run(run));
	always_comb o = '{led1, led2, led3, led4, led5, led6, power_indicator, safety_proto_indicator,
		network_indicator, port1_link_indicator, port2_link_indicator};
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// letter to colour: R G Y B O, anything else off
	function automatic sled_pkg::sled_colour_t col(input byte c);
		case (c)
			"R": return sled_pkg::SLED_RED;
			"G": return sled_pkg::SLED_GREEN;
			"Y": return sled_pkg::SLED_YELLOW;
			"B": return sled_pkg::SLED_BLUE;
			"O": return sled_pkg::SLED_ORANGE;
			default: return sled_pkg::SLED_OFF;
		endcase
	endfunction
	// watch led i over one blink period plus two cycles: s[0] colour when lit, s[1] the other phase
	task automatic chk(input int i, input string s);
		bit son = 0, soff = 0, bad = 0;
		repeat (3) @(negedge clk);
		repeat (2 * BHC + 2)
		begin
			@(negedge clk);
			if (o[i] === col(s[0])) son = 1;
			else if (o[i] === col(s[1])) soff = 1;
			else bad = 1;
		end
		samples_checked++;
		if (bad || !son || (s[0] != s[1] && !soff))
		begin
			fails++;
			$display("ERROR led%0d expected %s seen %0d", i + 1, s, o[i]);
		end
	endtask
	// powered, linked sensor present, everything else quiet
	task automatic clear();
		{safety_output_pair_on, error_present, restart_interlock_enabled, restart_interlock_released,
			protective_field_occupied, warning_field_interrupted, four_field_mode, warning_field3_interrupted,
			warning_field2_interrupted, self_test_fail, internal_comm_fault, locate_active, proto_initialised,
			proto_passive, proto_active, proto_config_fail, proto_comm_error, bus_initialised, bus_initialising,
			bus_data_exchange, topology_error, eth_config_fail, bus_error, port1_link, port1_traffic,
			port2_link, port2_traffic} = '0;
		powered = 1;
		linked_sensor_enabled = 1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		rst_b = 0;
		clear();
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_b = 1;
		chk(0, "RR");
		safety_output_pair_on = 1;
		chk(0, "GG");
		error_present = 1;
		chk(0, "R-");
		restart_interlock_enabled = 1;
		chk(1, "YY");
		protective_field_occupied = 1;
		chk(1, "Y-");
		restart_interlock_released = 1;
		protective_field_occupied = 0;
		chk(1, "--");
		warning_field_interrupted = 1;
		warning_field3_interrupted = 1;
		warning_field2_interrupted = 1;
		chk(2, "BB");
		chk(3, "--");
		four_field_mode = 1;
		chk(3, "BB");
		chk(4, "Y-");
		chk(5, "--");
		powered = 0;
		chk(0, "--");
		chk(6, "--");
		$display("test indicators 1 to 6 done");
		clear();
		chk(6, "GG");
		chk(7, "--");
		chk(8, "--");
		locate_active = 1;
		chk(6, "G-");
		chk(7, "G-");
		chk(8, "G-");
		self_test_fail = 1;
		chk(6, "RR");
		clear();
		internal_comm_fault = 1;
		proto_initialised = 1;
		proto_active = 1;
		bus_initialised = 1;
		bus_data_exchange = 1;
		chk(6, "RR");
		chk(7, "GG");
		chk(8, "GG");
		proto_passive = 1;
		bus_data_exchange = 0;
		chk(7, "G-");
		chk(8, "R-");
		proto_config_fail = 1;
		bus_initialising = 1;
		chk(7, "R-");
		chk(8, "G-");
		proto_comm_error = 1;
		topology_error = 1;
		chk(7, "RR");
		chk(8, "O-");
		eth_config_fail = 1;
		chk(8, "R-");
		bus_error = 1;
		chk(8, "RR");
		$display("test power, protocol and network done");
		clear();
		port1_link = 1;
		port2_link = 1;
		port2_traffic = 1;
		chk(9, "GG");
		chk(10, "GO");
		port1_traffic = 1;
		chk(9, "GO");
		// read the panel count once its falling-edge update has settled
		@(posedge clk);
		samples_checked++;
		if (run != BHC)
		begin
			fails++;
			$display("ERROR blink run expected %0d seen %0d", BHC, run);
		end
		@(negedge clk);
		port2_link = 0;
		chk(10, "--");
		$display("test port links done");
		summarize();
	end
endmodule
